// File: src/msd_pkg.sv
// Constants and types for the stepper driver SPI register block
package msd_pkg;
    localparam int          CTRL_NUM       = 4;
    localparam logic [4:0]  ADDR_WATCHDOG  = 5'h00;
    localparam logic [4:0]  ADDR_STEP_CUR  = 5'h01;
    localparam logic [4:0]  ADDR_DRIVE_OPT = 5'h02;
    localparam logic [4:0]  ADDR_MOTOR_PWR = 5'h03;
    localparam logic [4:0]  ADDR_STAT_BASE = 5'h04;
    localparam logic [4:0]  ADDR_STAT_LAST = 5'h07;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [3:0][7:0] CTRL_MASK  = {8'hF0, 8'hCF, 8'hFF, 8'hF8};
    localparam logic [4:0]  WRITE_BITS     = 5'h10;
    // Command byte fields
    localparam int CMD_WRITE_BIT = 7;
    // Watchdog register fields
    localparam int WD_KICK_BIT   = 7;
    localparam int WD_SEL_MSB    = 6;
    localparam int WD_SEL_LSB    = 3;
    // Step and current fields
    localparam int MSTEP_MSB     = 7;
    localparam int MSTEP_LSB     = 5;
    localparam int AMPL_MSB      = 4;
    // Drive option fields
    localparam int ROT_INV_BIT   = 7;
    localparam int EDGE_SEL_BIT  = 6;
    localparam int RATE_DBL_BIT  = 3;
    localparam int DITHER_BIT    = 2;
    localparam int SLOPE_MSB     = 1;
    // Motor power fields
    localparam int BRIDGE_BIT    = 7;
    localparam int SLEEP_BIT     = 6;
    localparam int GAIN_BIT      = 5;
    localparam int HOLD_BIT      = 4;
    // Status register 0 field for the watchdog boot flag
    localparam int BOOT_BIT      = 6;
    // Watchdog base interval
    localparam int UNIT_MS       = 32;
    localparam int CLK_KHZ       = 25000;
    localparam int WD_UNIT_CYC   = UNIT_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        PH_CMD  = 2'b01,
        PH_DATA = 2'b10
    } msd_phase_t;

    typedef struct packed {
        logic [2:0] microstep_select;
        logic [4:0] coil_amplitude;
        logic [1:0] edge_slope_sel;
        logic       chop_rate_double;
        logic       chop_dither;
        logic       bridge_output_on;
        logic       low_power_request;
        logic [3:0] dog_interval_sel;
    } msd_ctrl_t;

    typedef struct packed {
        logic [3:0][7:0] ctrl;
        logic [3:0][6:0] stat;
        logic [3:0]      clr_pend;
        logic            boot_ev;
        logic            fault;
        msd_phase_t      phase;
        logic [4:0]      bits;
        logic [2:0]      pos;
        logic            wr_cmd;
        logic [4:0]      addr;
        logic [7:0]      rx;
        logic [7:0]      data;
        logic [7:0]      tx;
        logic            wd_run;
        logic [23:0]     wd_unit;
        logic [3:0]      wd_units;
        logic            wd_fire;
        logic            dir_cw;
        logic            step;
        logic [7:0]      angle;
    } msd_state_t;

    localparam msd_state_t ST_RST = '{phase: PH_CMD, default: '0};
endpackage : msd_pkg

// File: src/msd_spi_regs.sv
// SPI slave engine and control/status register bank of the stepper driver
`timescale 1ns/100ps
`default_nettype none
module msd_spi_regs #(
    parameter logic [23:0] WD_UNIT_CYCLES = 24'(msd_pkg::WD_UNIT_CYC)
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic                spi_clk_pin,
    input  wire logic                chip_select_n,
    input  wire logic                spi_data_in,
    output logic                     spi_data_out,
    output logic                     spi_data_oe,
    output logic                     fault_out_n,
    output logic                     fault_out_oe,
    input  wire logic                hard_reset_pin,
    input  wire logic                step_advance_pin,
    input  wire logic                rotation_sense_pin,
    input  wire logic [3:0][6:0]     status_set,
    input  wire logic [7:0]          angle_level,
    output logic [7:0]               angle_feedback_out,
    output msd_pkg::msd_ctrl_t       ctrl_out,
    output logic                     step_pulse,
    output logic                     rotate_cw,
    output logic                     watchdog_reset
);
    import msd_pkg::*;

    msd_state_t st;
    msd_state_t next_st;
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] step_s;
    logic [1:0] mosi_s;
    logic [1:0] dir_s;
    logic [1:0] hrst_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_high;
    logic       cs_rise;
    logic       sleep;
    logic [7:0] rd_val;
    logic [7:0] rx_byte;

    function automatic logic is_stat(input logic [4:0] a);
        return (a >= ADDR_STAT_BASE) && (a <= ADDR_STAT_LAST);
    endfunction : is_stat

    // Pins are asynchronous to clk, so every one passes two flops first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s <= 3'h0;
            cs_s   <= 3'h7;
            step_s <= 3'h0;
            mosi_s <= 2'h0;
            dir_s  <= 2'h0;
            hrst_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], spi_clk_pin};
            cs_s   <= {cs_s[1:0], chip_select_n};
            step_s <= {step_s[1:0], step_advance_pin};
            mosi_s <= {mosi_s[0], spi_data_in};
            dir_s  <= {dir_s[0], rotation_sense_pin};
            hrst_s <= {hrst_s[0], hard_reset_pin};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign cs_high   = cs_s[1];
    assign cs_rise   = cs_s[1] & ~cs_s[2];
    assign sleep     = st.ctrl[ADDR_MOTOR_PWR][SLEEP_BIT];
    assign rx_byte   = {st.rx[6:0], mosi_s[1]};

    // Control reads back as stored; status gets parity on top
    always_comb begin
        rd_val = 8'h00;
        if (st.addr < ADDR_STAT_BASE) begin
            rd_val = st.ctrl[st.addr[1:0]];
        end else if (is_stat(st.addr)) begin
            rd_val = {^st.stat[st.addr[1:0]],
                      st.stat[st.addr[1:0]]};
        end
    end

    always_comb begin
        logic [3:0][6:0] stat_n;
        logic            kick;
        logic            boot_clr;
        stat_n   = st.stat;
        kick     = 1'b0;
        boot_clr = 1'b0;
        next_st  = st;
        next_st.wd_fire = 1'b0;
        next_st.step    = 1'b0;
        if (!cs_high) begin
            if (sclk_rise) begin
                next_st.rx   = rx_byte;
                next_st.pos  = next_st.pos + 3'h1;
                next_st.bits = (st.bits == 5'h1F) ? st.bits
                                                  : st.bits + 5'h01;
                if (st.pos == 3'h7) begin
                    case (st.phase)
                        PH_DATA: begin
                            next_st.data  = rx_byte;
                            next_st.phase = PH_CMD;
                        end
                        default: begin
                            // Any byte outside a write data slot is a command
                            next_st.addr   = rx_byte[4:0];
                            next_st.wr_cmd = rx_byte[CMD_WRITE_BIT];
                            next_st.phase  = rx_byte[CMD_WRITE_BIT]
                                             ? PH_DATA : PH_CMD;
                        end
                    endcase
                end
            end
            if (sclk_fall) begin
                if (st.pos == 3'h0 && st.bits != 5'h00) begin
                    next_st.tx = rd_val;
                    if (is_stat(st.addr)) begin
                        next_st.clr_pend[st.addr[1:0]] = 1'b1;
                    end
                end else begin
                    next_st.tx = {st.tx[6:0], 1'b0};
                end
            end
        end else begin
            if (cs_rise && st.bits == WRITE_BITS && st.wr_cmd
                && st.addr < ADDR_STAT_BASE) begin
                next_st.ctrl[st.addr[1:0]] =
                    st.data & CTRL_MASK[st.addr[1:0]];
                if (st.addr == ADDR_WATCHDOG) begin
                    kick     = st.data[WD_KICK_BIT];
                    boot_clr = ~st.data[WD_KICK_BIT];
                end
            end
            next_st.bits  = 5'h00;
            next_st.pos   = 3'h0;
            next_st.phase = PH_CMD;
            // New events are ORed after the clear so none coinciding with it is lost
            for (int i = 0; i < CTRL_NUM; i++) begin
                stat_n[i] = (st.stat[i] & ~{7{st.clr_pend[i]}})
                            | status_set[i];
            end
            if (boot_clr) begin
                stat_n[0][BOOT_BIT] = 1'b0;
            end
            stat_n[0][BOOT_BIT] = stat_n[0][BOOT_BIT] | st.boot_ev;
            next_st.boot_ev  = 1'b0;
            next_st.stat     = stat_n;
            next_st.clr_pend = 4'h0;
            // Boot flag reports a past reset, not an error
            next_st.fault = |{stat_n[3:1], stat_n[0][5:0]};
        end
        if (st.wd_run) begin
            if (st.wd_unit == WD_UNIT_CYCLES - 24'h1) begin
                next_st.wd_unit = 24'h0;
                if (st.wd_units == st.ctrl[ADDR_WATCHDOG][WD_SEL_MSB:WD_SEL_LSB])
                begin
                    next_st.wd_fire = 1'b1;
                    next_st.wd_run  = 1'b0;
                    next_st.boot_ev = 1'b1;
                end else begin
                    next_st.wd_units = st.wd_units + 4'h1;
                end
            end else begin
                next_st.wd_unit = st.wd_unit + 24'h1;
            end
        end
        if (kick) begin
            next_st.wd_run   = 1'b1;
            next_st.wd_unit  = 24'h0;
            next_st.wd_units = 4'h0;
        end
        if (!sleep) begin
            next_st.dir_cw = (dir_s[1] ==
                st.ctrl[ADDR_DRIVE_OPT][ROT_INV_BIT]);
            next_st.step = st.ctrl[ADDR_DRIVE_OPT][EDGE_SEL_BIT]
                ? (~step_s[1] & step_s[2])
                : (step_s[1] & ~step_s[2]);
        end
        if (!st.ctrl[ADDR_MOTOR_PWR][HOLD_BIT]) begin
            next_st.angle = st.ctrl[ADDR_MOTOR_PWR][GAIN_BIT]
                ? {2'b00, angle_level[7:2]}
                : {1'b0, angle_level[7:1]};
        end
        if (hrst_s[1]) begin
            next_st = ST_RST;
        end
    end

    // Shift and address registers reset to zero, so the first byte is junk
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Open-drain data line: pulled low only for zero bits while selected
    assign spi_data_out       = 1'b0;
    assign spi_data_oe        = ~cs_high & ~st.tx[7];
    assign fault_out_n        = 1'b0;
    assign fault_out_oe       = st.fault;
    assign angle_feedback_out = st.angle;
    assign step_pulse         = st.step;
    assign rotate_cw          = st.dir_cw;
    assign watchdog_reset     = st.wd_fire;
    assign ctrl_out.microstep_select =
        st.ctrl[ADDR_STEP_CUR][MSTEP_MSB:MSTEP_LSB];
    assign ctrl_out.coil_amplitude  = st.ctrl[ADDR_STEP_CUR][AMPL_MSB:0];
    assign ctrl_out.edge_slope_sel  = st.ctrl[ADDR_DRIVE_OPT][SLOPE_MSB:0];
    assign ctrl_out.chop_rate_double =
        st.ctrl[ADDR_DRIVE_OPT][RATE_DBL_BIT];
    assign ctrl_out.chop_dither     = st.ctrl[ADDR_DRIVE_OPT][DITHER_BIT];
    assign ctrl_out.bridge_output_on =
        st.ctrl[ADDR_MOTOR_PWR][BRIDGE_BIT] & ~sleep;
    assign ctrl_out.low_power_request = sleep;
    assign ctrl_out.dog_interval_sel =
        st.ctrl[ADDR_WATCHDOG][WD_SEL_MSB:WD_SEL_LSB];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    cmd_decode_a: assert property (
        !cs_high && sclk_rise && st.pos == 3'h7 && st.phase == PH_CMD
        && !hrst_s[1] |=> st.addr == $past(rx_byte[4:0])
        && st.phase == ($past(rx_byte[7]) ? PH_DATA : PH_CMD))
        else $error("command byte decoded wrongly");
    tx_load_a: assert property (
        !cs_high && sclk_fall && st.pos == 3'h0 && st.bits != 5'h00
        && !hrst_s[1] |=> st.tx == $past(rd_val))
        else $error("output shift register not loaded");
    parity_a: assert property (
        !cs_high && sclk_fall && st.pos == 3'h0 && st.bits != 5'h00
        && is_stat(st.addr) && !hrst_s[1]
        |=> st.tx[7] == ^st.tx[6:0])
        else $error("status parity wrong");
    fault_pin_a: assert property (
        cs_high && $past(cs_high) && !$past(hrst_s[1])
        |-> fault_out_oe == |{st.stat[3:1], st.stat[0][5:0]})
        else $error("fault pin disagrees with status");
    stat_frozen_a: assert property (
        !cs_high && !hrst_s[1] |=> $stable(st.stat) && $stable(st.fault))
        else $error("status changed while selected");
    read_clear_a: assert property (
        cs_high && !hrst_s[1] && $past(st.clr_pend[1])
        && !$past(status_set[1][0]) && $past(cs_high)
        |-> !st.stat[1][0])
        else $error("status not cleared after read");
    commit_a: assert property (
        cs_rise && st.bits == WRITE_BITS && st.wr_cmd
        && st.addr < ADDR_STAT_BASE && !hrst_s[1]
        |=> st.ctrl[$past(st.addr[1:0])] ==
            ($past(st.data) & CTRL_MASK[$past(st.addr[1:0])]))
        else $error("write data not committed");
    discard_a: assert property (
        (!cs_rise || st.bits != WRITE_BITS || !st.wr_cmd
         || st.addr >= ADDR_STAT_BASE) && !hrst_s[1]
        |=> $stable(st.ctrl))
        else $error("control changed without a valid write");
    sleep_step_a: assert property (
        sleep && !hrst_s[1] |=> !step_pulse && $stable(rotate_cw))
        else $error("step pins not ignored in sleep");

    write_cov: cover property (cs_rise && st.bits == WRITE_BITS && st.wr_cmd);
    status_cov: cover property (sclk_fall && is_stat(st.addr) && !cs_high);
    sleep_cov: cover property (sleep ##1 step_s[1] != step_s[2]);
    dog_cov: cover property (watchdog_reset);
endmodule : msd_spi_regs
`default_nettype wire

// File: test/msd_spi_master.sv
// SPI master model that drives the register link in mode 0
`timescale 1ns/100ps
`default_nettype none
module msd_spi_master (
    input  wire logic clk,
    input  wire logic data_line,
    output logic      spi_clk_pin,
    output logic      chip_select_n,
    output logic      spi_data_in
);
    initial begin
        spi_clk_pin   = 1'b0;
        chip_select_n = 1'b1;
        spi_data_in   = 1'b0;
    end

    // Gaps on both sides let the synchronised select settle in the device
    task automatic select(input logic on);
        repeat (6) @(negedge clk);
        chip_select_n = !on;
        spi_data_in   = !spi_data_in;
        repeat (6) @(negedge clk);
    endtask : select

    // Read at the end of the high half, where the answer bit is settled
    task automatic bit_io(input logic b, output logic r);
        spi_data_in = b;
        repeat (4) @(negedge clk);
        spi_clk_pin = 1'b1;
        repeat (4) @(negedge clk);
        r           = data_line;
        spi_clk_pin = 1'b0;
    endtask : bit_io

    task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
    endtask : byte_io
endmodule : msd_spi_master
`default_nettype wire

// File: test/test_msd_spi_regs.sv
// Self-checking bench for the stepper driver SPI register block
`timescale 1ns/100ps
`default_nettype none
module test_msd_spi_regs;
    import msd_pkg::*;
    logic            clk;
    logic            arst_n;
    logic            spi_clk_pin;
    logic            chip_select_n;
    logic            spi_data_in;
    logic            spi_data_oe;
    logic            spi_data_out;
    logic            fault_out_oe;
    logic            fault_out_n;
    logic            hard_reset_pin;
    logic            step_advance_pin;
    logic            rotation_sense_pin;
    logic [3:0][6:0] status_set;
    logic [7:0]      angle_level;
    logic [7:0]      angle_feedback_out;
    msd_ctrl_t       ctrl_out;
    logic            step_pulse;
    logic            rotate_cw;
    logic            watchdog_reset;
    wire logic       data_line;
    wire logic       fault_line;
    int              err_count;
    int              tests_run;
    int              step_cnt = 0;
    logic [7:0]      q;

    // Pull-up on the data line; the device can only pull it low
    assign data_line  = spi_data_oe ? spi_data_out : 1'b1;
    assign fault_line = fault_out_oe ? fault_out_n : 1'b1;

    msd_spi_regs #(.WD_UNIT_CYCLES(24'h000010)) msd_spi_regs_i (
        .clk(clk), .arst_n(arst_n), .spi_clk_pin(spi_clk_pin),
        .chip_select_n(chip_select_n), .spi_data_in(spi_data_in),
        .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
        .fault_out_n(fault_out_n),
        .fault_out_oe(fault_out_oe), .hard_reset_pin(hard_reset_pin),
        .step_advance_pin(step_advance_pin),
        .rotation_sense_pin(rotation_sense_pin), .status_set(status_set),
        .angle_level(angle_level), .angle_feedback_out(angle_feedback_out),
        .ctrl_out(ctrl_out), .step_pulse(step_pulse),
        .rotate_cw(rotate_cw), .watchdog_reset(watchdog_reset));

    msd_spi_master msd_spi_master_i (
        .clk(clk), .data_line(data_line), .spi_clk_pin(spi_clk_pin),
        .chip_select_n(chip_select_n), .spi_data_in(spi_data_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = !clk;
    end

    always @(posedge clk) begin
        if (step_pulse === 1'b1) step_cnt <= step_cnt + 1;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Two chained reads in one select period; the first byte out is stale
    task automatic rd2(input logic [4:0] a, input logic [4:0] b,
                       input logic [7:0] ea, input logic [7:0] eb);
        msd_spi_master_i.select(1'b1);
        msd_spi_master_i.byte_io({3'b000, a}, q);
        msd_spi_master_i.byte_io({3'b000, b}, q);
        check("read_a", q, ea);
        msd_spi_master_i.byte_io(8'h00, q);
        check("read_b", q, eb);
        msd_spi_master_i.select(1'b0);
    endtask : rd2

    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [7:0] old);
        msd_spi_master_i.select(1'b1);
        msd_spi_master_i.byte_io({3'b100, a}, q);
        msd_spi_master_i.byte_io(d, q);
        check("write_old", q, old);
        msd_spi_master_i.select(1'b0);
    endtask : wr

    task automatic bad_wr(input int n);
        logic b;
        msd_spi_master_i.select(1'b1);
        msd_spi_master_i.byte_io(8'h82, q);
        for (int i = 0; i < n; i++) msd_spi_master_i.bit_io(1'b1, b);
        msd_spi_master_i.select(1'b0);
    endtask : bad_wr

    task automatic hard_rst();
        hard_reset_pin = 1'b1;
        repeat (8) @(negedge clk);
        hard_reset_pin = 1'b0;
        repeat (4) @(negedge clk);
    endtask : hard_rst

    task automatic wait_wd(input int lim);
        for (int n = 0; watchdog_reset !== 1'b1; n++) begin
            @(negedge clk);
            if (n > lim) begin
                err_count++;
                $display("CHECK FAILED watchdog_pulse expected 1 seen 0");
                stop_test();
            end
        end
    endtask : wait_wd

    task automatic stp(input logic lvl, input logic [7:0] exp);
        step_advance_pin = lvl;
        repeat (8) @(negedge clk);
        check("steps", 8'(step_cnt), exp);
    endtask : stp

    initial begin
        arst_n = 1'b0;
        hard_reset_pin = 1'b0;
        step_advance_pin = 1'b0;
        rotation_sense_pin = 1'b0;
        status_set = '0;
        angle_level = 8'hB4;
        err_count = 0;
        tests_run = 0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd2(5'h00, 5'h01, 8'h00, 8'h00);
        rd2(5'h02, 5'h03, 8'h00, 8'h00);
        rd2(5'h08, 5'h1F, 8'h00, 8'h00);
        for (int i = 0; i < CTRL_NUM; i++) begin
            wr(5'(i), 8'hFF, 8'h00);
            rd2(5'(i), 5'(i), CTRL_MASK[i], CTRL_MASK[i]);
        end
        hard_rst();
        rd2(5'h00, 5'h03, 8'h00, 8'h00);
        rd2(5'h04, 5'h02, 8'h00, 8'h00);
        msd_spi_master_i.select(1'b1);
        msd_spi_master_i.byte_io(8'h81, q);
        msd_spi_master_i.byte_io(8'hA5, q);
        check("early", 8'(ctrl_out.microstep_select), 8'h00);
        msd_spi_master_i.select(1'b0);
        check("mstep", 8'(ctrl_out.microstep_select), 8'h05);
        check("coil", 8'(ctrl_out.coil_amplitude), 8'h05);
        bad_wr(7);
        bad_wr(9);
        rd2(5'h02, 5'h01, 8'h00, 8'hA5);
        wr(5'h04, 8'h7F, 8'h00);
        rd2(5'h04, 5'h01, 8'h00, 8'hA5);
        status_set = {7'h7F, 7'h00, 7'h07, 7'h01};
        @(negedge clk);
        status_set = '0;
        repeat (4) @(negedge clk);
        check("fault_set", 8'(fault_out_oe), 8'h01);
        check("fault_pin", 8'(fault_line), 8'h00);
        rd2(5'h05, 5'h05, 8'h87, 8'h87);
        check("fault_keep", 8'(fault_out_oe), 8'h01);
        rd2(5'h07, 5'h04, 8'hFF, 8'h81);
        repeat (4) @(negedge clk);
        check("fault_clr", 8'(fault_out_oe), 8'h00);
        check("fault_idle", 8'(fault_line), 8'h01);
        rd2(5'h05, 5'h06, 8'h00, 8'h00);
        rd2(5'h07, 5'h04, 8'h00, 8'h00);
        msd_spi_master_i.select(1'b1);
        status_set[2] = 7'h01;
        @(negedge clk);
        status_set = '0;
        msd_spi_master_i.select(1'b0);
        check("frozen", 8'(fault_out_oe), 8'h00);
        rd2(5'h06, 5'h06, 8'h00, 8'h00);
        wr(5'h00, 8'h80, 8'h00);
        wait_wd(64);
        rd2(5'h04, 5'h04, 8'hC0, 8'hC0);
        check("boot_no_fault", 8'(fault_out_oe), 8'h00);
        wr(5'h00, 8'hF8, 8'h80);
        check("interval", 8'(ctrl_out.dog_interval_sel), 8'h0F);
        wait_wd(400);
        wr(5'h00, 8'h78, 8'hF8);
        rd2(5'h04, 5'h00, 8'h00, 8'h78);
        hard_rst();
        check("cw", 8'(rotate_cw), 8'h01);
        stp(1'b1, 8'h01);
        stp(1'b0, 8'h01);
        wr(5'h02, 8'hCD, 8'h00);
        q = 8'({ctrl_out.chop_rate_double, ctrl_out.chop_dither});
        check("chop", q, 8'h03);
        check("slope", 8'(ctrl_out.edge_slope_sel), 8'h01);
        check("ccw", 8'(rotate_cw), 8'h00);
        rotation_sense_pin = 1'b1;
        stp(1'b1, 8'h01);
        check("cw_inv", 8'(rotate_cw), 8'h01);
        stp(1'b0, 8'h02);
        wr(5'h03, 8'hC0, 8'h00);
        check("bridge_slp", 8'(ctrl_out.bridge_output_on), 8'h00);
        check("sleep", 8'(ctrl_out.low_power_request), 8'h01);
        rotation_sense_pin = 1'b0;
        stp(1'b1, 8'h02);
        stp(1'b0, 8'h02);
        check("dir_held", 8'(rotate_cw), 8'h01);
        wr(5'h03, 8'h80, 8'hC0);
        check("bridge_on", 8'(ctrl_out.bridge_output_on), 8'h01);
        check("angle_half", angle_feedback_out, 8'h5A);
        wr(5'h03, 8'hA0, 8'h80);
        check("angle_qtr", angle_feedback_out, 8'h2D);
        wr(5'h03, 8'hB0, 8'hA0);
        angle_level = 8'h40;
        repeat (4) @(negedge clk);
        check("angle_hold", angle_feedback_out, 8'h2D);
        wr(5'h03, 8'hA0, 8'hB0);
        check("angle_track", angle_feedback_out, 8'h10);
        stop_test();
    end
endmodule : test_msd_spi_regs
`default_nettype wire
